// *** include/irq_pkg.sv ***
package irq_pkg;
	localparam int SRC_N = 11;
	typedef logic [SRC_N-1:0] src_vec_t;
	typedef logic [15:0]      vec_addr_t;
	typedef logic [3:0]       src_idx_t;
	// Polling positions, first to last
	localparam src_idx_t SRC_EXT_A   = 4'h0;
	localparam src_idx_t SRC_TIMER_A = 4'h1;
	localparam src_idx_t SRC_EXT_B   = 4'h2;
	localparam src_idx_t SRC_TIMER_B = 4'h3;
	localparam src_idx_t SRC_SER_A   = 4'h4;
	localparam src_idx_t SRC_TIMER_C = 4'h5;
	localparam src_idx_t SRC_SPI     = 4'h6;
	localparam src_idx_t SRC_TWI     = 4'h7;
	localparam src_idx_t SRC_CONV    = 4'h8;
	localparam src_idx_t SRC_ARRAY   = 4'h9;
	localparam src_idx_t SRC_SER_B   = 4'ha;
	// Vector addresses in polling order
	localparam vec_addr_t VEC_EXT_A   = 16'h0003;
	localparam vec_addr_t VEC_TIMER_A = 16'h000b;
	localparam vec_addr_t VEC_EXT_B   = 16'h0013;
	localparam vec_addr_t VEC_TIMER_B = 16'h001b;
	localparam vec_addr_t VEC_SER_A   = 16'h0023;
	localparam vec_addr_t VEC_TIMER_C = 16'h002b;
	localparam vec_addr_t VEC_SPI     = 16'h0053;
	localparam vec_addr_t VEC_TWI     = 16'h0043;
	localparam vec_addr_t VEC_CONV    = 16'h003b;
	localparam vec_addr_t VEC_ARRAY   = 16'h005b;
	localparam vec_addr_t VEC_SER_B   = 16'h004b;
	localparam vec_addr_t VEC_TABLE [SRC_N] = '{VEC_EXT_A, VEC_TIMER_A, VEC_EXT_B, VEC_TIMER_B, VEC_SER_A,
		VEC_TIMER_C, VEC_SPI, VEC_TWI, VEC_CONV, VEC_ARRAY, VEC_SER_B};
	// Trigger select: 1 is falling edge, 0 is low level
	localparam logic TRIG_EDGE = 1'b1;
	localparam logic PIN_IDLE  = 1'b1;
	localparam logic LEVEL_HIGH = 1'b1;
	localparam int SPI_FLAGS   = 4;
	localparam int ARRAY_MATCH = 6;
	localparam int ARRAY_WRAP  = 2;
	localparam int ARRAY_FLAGS = ARRAY_MATCH + ARRAY_WRAP;
endpackage : irq_pkg

// *** design/flag_cell.sv ***
`timescale 1ns/1ps
// Sticky flags; a set in the clearing cycle wins
module flag_cell #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);
	logic [W-1:0] next_q;

	// Set over clear so no event is lost
	always_comb begin
		next_q = (q & ~clr) | set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule : flag_cell

// *** design/two_level_interrupt_unit.sv ***
`timescale 1ns/1ps
module two_level_interrupt_unit (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic                                mc_en,
	input  wire logic                                core_poll_ok,
	input  wire logic                                core_reti,
	input  wire logic                                global_irq_enable,
	input  wire logic                                ext_a_enable,
	input  wire logic                                timer_a_enable,
	input  wire logic                                ext_b_enable,
	input  wire logic                                timer_b_enable,
	input  wire logic                                serial_a_enable,
	input  wire logic                                timer_c_enable,
	input  wire logic                                spi_irq_enable,
	input  wire logic                                twi_irq_enable,
	input  wire logic                                conv_irq_enable,
	input  wire logic                                array_irq_enable,
	input  wire logic                                serial_b_enable,
	input  wire logic                                ext_a_level,
	input  wire logic                                timer_a_level,
	input  wire logic                                ext_b_level,
	input  wire logic                                timer_b_level,
	input  wire logic                                serial_a_level,
	input  wire logic                                timer_c_level,
	input  wire logic                                spi_irq_level,
	input  wire logic                                twi_irq_level,
	input  wire logic                                conv_irq_level,
	input  wire logic                                array_irq_level,
	input  wire logic                                serial_b_level,
	input  wire logic                                ext_req_pin_a,
	input  wire logic                                ext_req_pin_b,
	input  wire logic                                ext_a_trigger_type,
	input  wire logic                                ext_b_trigger_type,
	input  wire logic                                timer_a_overflow,
	input  wire logic                                timer_a_mode3,
	input  wire logic                                timer_b_overflow,
	input  wire logic                                timer_c_overflow,
	input  wire logic                                timer_c_capture_pin,
	input  wire logic [1:0]                          timer_c_flag_clear,
	input  wire logic                                serial_a_rx_done,
	input  wire logic                                serial_a_tx_done,
	input  wire logic [1:0]                          serial_a_flag_clear,
	input  wire logic                                serial_b_rx_done,
	input  wire logic                                serial_b_tx_done,
	input  wire logic [1:0]                          serial_b_flag_clear,
	input  wire logic [irq_pkg::SPI_FLAGS-1:0]       spi_events,
	input  wire logic                                twi_own_address,
	input  wire logic                                twi_general_call_flag,
	input  wire logic                                twi_stop_seen,
	input  wire logic                                twi_byte_done,
	input  wire logic                                conv_done,
	input  wire logic                                conv_flag_clear,
	input  wire logic [irq_pkg::ARRAY_MATCH-1:0]     array_match_events,
	input  wire logic [irq_pkg::ARRAY_WRAP-1:0]      array_wrap_events,
	input  wire logic [irq_pkg::ARRAY_FLAGS-1:0]     array_flag_clear,
	output logic                                     ext_a_pending,
	output logic                                     ext_b_pending,
	output logic                                     timer_a_overflow_flag,
	output logic                                     timer_b_overflow_flag,
	output logic [1:0]                               timer_c_flags,
	output logic [1:0]                               serial_a_flags,
	output logic [1:0]                               serial_b_flags,
	output logic [irq_pkg::SPI_FLAGS-1:0]            spi_flags,
	output logic                                     twi_request_flag,
	output logic                                     conv_done_flag,
	output logic [irq_pkg::ARRAY_FLAGS-1:0]          array_flags,
	output logic                                     lcall_req,
	output irq_pkg::vec_addr_t                       lcall_vector,
	output logic                                     in_service_high,
	output logic                                     in_service_low
);
	import irq_pkg::*;

	src_vec_t  req;
	src_vec_t  enable;
	src_vec_t  level;
	src_vec_t  sampled;
	src_vec_t  next_sampled;
	src_vec_t  svc_clr;
	logic      pin_a_prev;
	logic      pin_b_prev;
	logic      cap_prev;
	logic      next_pin_a_prev;
	logic      next_pin_b_prev;
	logic      next_cap_prev;
	logic      next_ext_a_pending;
	logic      next_ext_b_pending;
	logic      hi_hit;
	logic      lo_hit;
	src_idx_t  hi_idx;
	src_idx_t  lo_idx;
	logic      permit_hi;
	logic      permit_lo;
	logic      accept;
	src_idx_t  winner;
	logic      next_lcall_req;
	vec_addr_t next_lcall_vector;
	logic      next_in_service_high;
	logic      next_in_service_low;

	// Request lines in polling order, one per source
	always_comb begin
		req[SRC_EXT_A]   = ext_a_pending;
		req[SRC_TIMER_A] = timer_a_overflow_flag;
		req[SRC_EXT_B]   = ext_b_pending;
		req[SRC_TIMER_B] = timer_b_overflow_flag;
		req[SRC_SER_A]   = |serial_a_flags;
		req[SRC_TIMER_C] = |timer_c_flags;
		req[SRC_SPI]     = |spi_flags;
		req[SRC_TWI]     = twi_request_flag;
		req[SRC_CONV]    = conv_done_flag;
		req[SRC_ARRAY]   = |array_flags;
		req[SRC_SER_B]   = |serial_b_flags;
	end

	// Enable and level bits gathered in the same order
	always_comb begin
		enable = {serial_b_enable, array_irq_enable, conv_irq_enable, twi_irq_enable, spi_irq_enable,
			timer_c_enable, serial_a_enable, timer_b_enable, ext_b_enable, timer_a_enable, ext_a_enable};
		level = {serial_b_level, array_irq_level, conv_irq_level, twi_irq_level, spi_irq_level,
			timer_c_level, serial_a_level, timer_b_level, ext_b_level, timer_a_level, ext_a_level};
	end

	// Fixed-order pick of the first request in each level
	always_comb begin
		hi_hit = 1'b0;
		lo_hit = 1'b0;
		hi_idx = SRC_EXT_A;
		lo_idx = SRC_EXT_A;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (sampled[i] && level[i] == LEVEL_HIGH) begin
				hi_hit = 1'b1;
				hi_idx = src_idx_t'(i);
			end
			if (sampled[i] && level[i] != LEVEL_HIGH) begin
				lo_hit = 1'b1;
				lo_idx = src_idx_t'(i);
			end
		end
	end

	// Arbitration against what is already in service
	always_comb begin
		permit_hi = hi_hit && !in_service_high;
		permit_lo = lo_hit && !in_service_high && !in_service_low;
		accept    = mc_en && core_poll_ok && (permit_hi || permit_lo);
		winner    = permit_hi ? hi_idx : lo_idx;
		svc_clr   = '0;
		if (accept) begin
			svc_clr[winner] = 1'b1;
		end
	end

	// Sampling, external inputs and service bookkeeping
	always_comb begin
		next_pin_a_prev = ext_req_pin_a;
		next_pin_b_prev = ext_req_pin_b;
		next_cap_prev   = timer_c_capture_pin;
		// Fresh sample each machine cycle; a denied request is not held
		next_sampled = sampled;
		if (mc_en) begin
			next_sampled = global_irq_enable ? (req & enable) : '0;
		end
		// Edge mode keeps the flag until service, level mode tracks the pin
		if (ext_a_trigger_type == TRIG_EDGE) begin
			next_ext_a_pending = (ext_a_pending && !svc_clr[SRC_EXT_A]) || (pin_a_prev && !ext_req_pin_a);
		end else begin
			next_ext_a_pending = !ext_req_pin_a;
		end
		if (ext_b_trigger_type == TRIG_EDGE) begin
			next_ext_b_pending = (ext_b_pending && !svc_clr[SRC_EXT_B]) || (pin_b_prev && !ext_req_pin_b);
		end else begin
			next_ext_b_pending = !ext_req_pin_b;
		end
		next_lcall_req       = accept;
		next_lcall_vector    = accept ? VEC_TABLE[winner] : lcall_vector;
		next_in_service_high = in_service_high;
		next_in_service_low  = in_service_low;
		// Return retires the innermost routine, which is high when both run
		if (core_reti) begin
			if (in_service_high) begin
				next_in_service_high = 1'b0;
			end else begin
				next_in_service_low = 1'b0;
			end
		end
		if (accept && permit_hi) begin
			next_in_service_high = 1'b1;
		end else if (accept) begin
			next_in_service_low = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_a_prev      <= PIN_IDLE;
			pin_b_prev      <= PIN_IDLE;
			cap_prev        <= PIN_IDLE;
			ext_a_pending   <= 1'b0;
			ext_b_pending   <= 1'b0;
			sampled         <= '0;
			lcall_req       <= 1'b0;
			lcall_vector    <= VEC_EXT_A;
			in_service_high <= 1'b0;
			in_service_low  <= 1'b0;
		end else begin
			pin_a_prev      <= next_pin_a_prev;
			pin_b_prev      <= next_pin_b_prev;
			cap_prev        <= next_cap_prev;
			ext_a_pending   <= next_ext_a_pending;
			ext_b_pending   <= next_ext_b_pending;
			sampled         <= next_sampled;
			lcall_req       <= next_lcall_req;
			lcall_vector    <= next_lcall_vector;
			in_service_high <= next_in_service_high;
			in_service_low  <= next_in_service_low;
		end
	end
	// Timer A and B overflow flags, cleared by their own service
	flag_cell #(.W(2)) u_timer_ab (
		.clk   (clk),
		.rst_n (rst_n),
		.set   ({timer_b_overflow, timer_a_overflow && !timer_a_mode3}),
		.clr   ({svc_clr[SRC_TIMER_B], svc_clr[SRC_TIMER_A]}),
		.q     ({timer_b_overflow_flag, timer_a_overflow_flag})
	);
	// Timer C: bit 1 capture, bit 0 overflow; software clears
	flag_cell #(.W(2)) u_timer_c (
		.clk   (clk),
		.rst_n (rst_n),
		.set   ({cap_prev && !timer_c_capture_pin, timer_c_overflow}),
		.clr   (timer_c_flag_clear),
		.q     (timer_c_flags)
	);
	// Serial flags: bit 1 transmit, bit 0 receive; software clears
	flag_cell #(.W(2)) u_serial_a (
		.clk   (clk),
		.rst_n (rst_n),
		.set   ({serial_a_tx_done, serial_a_rx_done}),
		.clr   (serial_a_flag_clear),
		.q     (serial_a_flags)
	);
	flag_cell #(.W(2)) u_serial_b (
		.clk   (clk),
		.rst_n (rst_n),
		.set   ({serial_b_tx_done, serial_b_rx_done}),
		.clr   (serial_b_flag_clear),
		.q     (serial_b_flags)
	);
	// SPI and TWI flags drop on service entry
	flag_cell #(.W(SPI_FLAGS)) u_spi (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (spi_events),
		.clr   ({SPI_FLAGS{svc_clr[SRC_SPI]}}),
		.q     (spi_flags)
	);
	flag_cell #(.W(1)) u_twi (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (twi_own_address || twi_general_call_flag || twi_stop_seen || twi_byte_done),
		.clr   (svc_clr[SRC_TWI]),
		.q     (twi_request_flag)
	);
	// Converter and counter array flags wait for software
	flag_cell #(.W(1)) u_conv (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (conv_done),
		.clr   (conv_flag_clear),
		.q     (conv_done_flag)
	);
	flag_cell #(.W(ARRAY_FLAGS)) u_array (
		.clk   (clk),
		.rst_n (rst_n),
		.set   ({array_wrap_events, array_match_events}),
		.clr   (array_flag_clear),
		.q     (array_flags)
	);
	global_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mc_en && !global_irq_enable) |=> (sampled == '0)) else $error("sample taken while globally off");
	enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mc_en && !ext_a_enable) |=> !sampled[SRC_EXT_A]) else $error("disabled source sampled");
	sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mc_en |=> $stable(sampled)) else $error("sample changed between machine cycles");
	timer_c_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && winner == SRC_TIMER_C) |=> (lcall_req && lcall_vector == 16'h002b)) else $error("timer c vector");
	edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ext_a_trigger_type && $past(ext_req_pin_a) && !ext_req_pin_a) |=> ext_a_pending) else $error("edge lost");
	level_track_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!ext_b_trigger_type && !ext_req_pin_b) |=> ext_b_pending) else $error("low level not pending");
	mode3_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		(timer_a_mode3 && !timer_a_overflow_flag) |=> !timer_a_overflow_flag) else $error("mode 3 overflow");
	high_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		in_service_high |=> !lcall_req) else $error("call while high level in service");
	spi_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && winner == SRC_SPI && spi_events == '0) |=> (spi_flags == '0)) else $error("spi flags kept");
	call_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
		lcall_req |-> ($past(mc_en) && $past(core_poll_ok))) else $error("call outside poll slot");
endmodule : two_level_interrupt_unit

// *** verification/core_model.sv ***
`timescale 1ns/1ps
// Core side: paces machine cycles, takes forced calls, returns on request
module core_model #(
	parameter int MC = 4
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               lcall_req,
	input  wire irq_pkg::vec_addr_t lcall_vector,
	input  wire logic               hold,
	input  wire logic               ret_req,
	output logic                    mc_en,
	output logic                    core_poll_ok,
	output logic                    core_reti,
	output int                      calls,
	output irq_pkg::vec_addr_t      got_vec
);
	import irq_pkg::*;
	int ph;
	// Slot strobe every MC clocks; hold stands for an instruction short of its last cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			ph <= 0;
			mc_en <= 1'b0;
			core_poll_ok <= 1'b0;
			core_reti <= 1'b0;
			calls <= 0;
			got_vec <= '0;
		end else begin
			ph <= (ph == MC - 1) ? 0 : ph + 1;
			mc_en <= (ph == MC - 1);
			core_poll_ok <= ~hold;
			core_reti <= ret_req;
			if (lcall_req) begin
				calls <= calls + 1;
				got_vec <= lcall_vector;
			end
		end
	end
endmodule : core_model

// *** verification/two_level_interrupt_unit_tb.sv ***
`timescale 1ns/1ps
module two_level_interrupt_unit_tb;
	import irq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic global_irq_enable = 1'b1;
	logic ext_a_trigger_type = 1'b1;
	logic ext_b_trigger_type = 1'b1;
	logic timer_a_mode3 = 1'b0;
	logic hold = 1'b0;
	logic ret_req = 1'b0;
	logic alt = 1'b0;
	src_vec_t en = '1;
	src_vec_t lv = '0;
	src_vec_t ev = '0;
	src_vec_t clrv = '0;
	src_vec_t pend;
	int calls;
	int seen = 0;
	int fail_count = 0;
	int total_checks = 0;
	vec_addr_t lcall_vector, got_vec;
	logic mc_en, core_poll_ok, core_reti, lcall_req, in_service_high, in_service_low;
	logic ext_a_enable, timer_a_enable, ext_b_enable, timer_b_enable, serial_a_enable, timer_c_enable;
	logic spi_irq_enable, twi_irq_enable, conv_irq_enable, array_irq_enable, serial_b_enable;
	logic ext_a_level, timer_a_level, ext_b_level, timer_b_level, serial_a_level, timer_c_level;
	logic spi_irq_level, twi_irq_level, conv_irq_level, array_irq_level, serial_b_level;
	logic ext_req_pin_a, ext_req_pin_b, timer_a_overflow, timer_b_overflow, timer_c_overflow, timer_c_capture_pin;
	logic serial_a_rx_done, serial_a_tx_done, serial_b_rx_done, serial_b_tx_done, conv_done, conv_flag_clear;
	logic twi_own_address, twi_general_call_flag, twi_stop_seen, twi_byte_done;
	logic ext_a_pending, ext_b_pending, timer_a_overflow_flag, timer_b_overflow_flag, twi_request_flag, conv_done_flag;
	logic [1:0] timer_c_flag_clear, serial_a_flag_clear, serial_b_flag_clear;
	logic [1:0] timer_c_flags, serial_a_flags, serial_b_flags;
	logic [SPI_FLAGS-1:0] spi_events, spi_flags;
	logic [ARRAY_MATCH-1:0] array_match_events;
	logic [ARRAY_WRAP-1:0] array_wrap_events;
	logic [ARRAY_FLAGS-1:0] array_flag_clear, array_flags;
	// Vectors in poll order, and which sources lose their flag on service
	localparam vec_addr_t EXP [SRC_N] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
		16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
	localparam src_vec_t AUTO = 11'h0cf;

	// Enable and level bits in poll order
	assign {serial_b_enable, array_irq_enable, conv_irq_enable, twi_irq_enable, spi_irq_enable, timer_c_enable,
		serial_a_enable, timer_b_enable, ext_b_enable, timer_a_enable, ext_a_enable} = en;
	assign {serial_b_level, array_irq_level, conv_irq_level, twi_irq_level, spi_irq_level, timer_c_level,
		serial_a_level, timer_b_level, ext_b_level, timer_a_level, ext_a_level} = lv;
	// One event line per source; alt steers it to the source's other cause
	assign ext_req_pin_a = ~ev[0];
	assign ext_req_pin_b = ~ev[2];
	assign timer_a_overflow = ev[1];
	assign timer_b_overflow = ev[3];
	assign serial_a_rx_done = ev[4] & ~alt;
	assign serial_a_tx_done = ev[4] & alt;
	assign timer_c_overflow = ev[5] & ~alt;
	assign timer_c_capture_pin = ~(ev[5] & alt);
	assign spi_events = {{2{ev[6] & alt}}, {2{ev[6] & ~alt}}};
	assign twi_own_address = ev[7] & ~alt;
	assign twi_byte_done = ev[7] & ~alt;
	assign twi_general_call_flag = ev[7] & alt;
	assign twi_stop_seen = ev[7] & alt;
	assign conv_done = ev[8];
	assign array_match_events = {ARRAY_MATCH{ev[9] & ~alt}};
	assign array_wrap_events = {ARRAY_WRAP{ev[9] & alt}};
	assign serial_b_rx_done = ev[10] & ~alt;
	assign serial_b_tx_done = ev[10] & alt;
	// Software clears of the flags that service leaves set
	assign timer_c_flag_clear = {2{clrv[5]}};
	assign serial_a_flag_clear = {2{clrv[4]}};
	assign serial_b_flag_clear = {2{clrv[10]}};
	assign conv_flag_clear = clrv[8];
	assign array_flag_clear = {ARRAY_FLAGS{clrv[9]}};
	assign pend = {|serial_b_flags, |array_flags, conv_done_flag, twi_request_flag, |spi_flags, |timer_c_flags,
		|serial_a_flags, timer_b_overflow_flag, ext_b_pending, timer_a_overflow_flag, ext_a_pending};

	two_level_interrupt_unit u_two_level_interrupt_unit (.*);
	core_model u_core_model (.clk(clk), .rst_n(rst_n), .lcall_req(lcall_req), .lcall_vector(lcall_vector),
		.hold(hold), .ret_req(ret_req), .mc_en(mc_en), .core_poll_ok(core_poll_ok), .core_reti(core_reti),
		.calls(calls), .got_vec(got_vec));

	// 40 MHz clock
	initial forever #12.5 clk = ~clk;

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic fire(input src_vec_t m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= '0;
	endtask : fire
	task automatic clear(input src_vec_t m);
		@(posedge clk);
		clrv <= m;
		@(posedge clk);
		clrv <= '0;
	endtask : clear
	task automatic ret;
		@(posedge clk);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
	endtask : ret
	// Bounded wait; a missing call ends the run
	task automatic wait_call(input vec_addr_t exp);
		for (int i = 0; i < 64 && calls == seen; i++) @(negedge clk);
		if (calls == seen) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, 16'(calls), 16'(seen + 1));
			test_done();
		end
		seen++;
		cmp(got_vec, exp);
	endtask : wait_call
	task automatic no_call(input int n);
		cyc(n);
		cmp(16'(calls), 16'(seen));
	endtask : no_call

	// Every source at once, low level, served one by one in poll order
	task automatic t_order(input logic a);
		@(posedge clk);
		alt <= a;
		hold <= 1'b1;
		fire('1);
		cyc(3);
		cmp(16'(pend), 16'h07ff);
		cmp(16'(timer_c_flags), 16'({a, ~a}));
		cyc(8);
		@(posedge clk);
		hold <= 1'b0;
		for (int i = 0; i < SRC_N; i++) begin
			wait_call(EXP[i]);
			cyc(1);
			cmp(16'(pend[i]), 16'(!AUTO[i]));
			cmp(16'(in_service_low), 16'h0001);
			clear(src_vec_t'(1) << i);
			cyc(10);
			ret();
		end
		no_call(16);
	endtask : t_order
	// Source enable, then global enable, each blocks alone
	task automatic t_block;
		@(posedge clk);
		en <= '0;
		fire(11'h002);
		no_call(20);
		@(posedge clk);
		en <= '1;
		global_irq_enable <= 1'b0;
		no_call(20);
		@(posedge clk);
		global_irq_enable <= 1'b1;
		wait_call(EXP[1]);
		ret();
	endtask : t_block
	// Low in service: same level waits, high preempts, low resumes later
	task automatic t_prio;
		@(posedge clk);
		lv <= 11'h002;
		fire(11'h008);
		wait_call(EXP[3]);
		fire(11'h008);
		no_call(20);
		fire(11'h002);
		wait_call(EXP[1]);
		cmp(16'(in_service_high), 16'h0001);
		ret();
		no_call(12);
		ret();
		wait_call(EXP[3]);
		ret();
		@(posedge clk);
		lv <= '0;
	endtask : t_prio
	// Counting mode 3 suppresses the timer A flag
	task automatic t_mode3;
		@(posedge clk);
		timer_a_mode3 <= 1'b1;
		fire(11'h002);
		cyc(2);
		cmp(16'(timer_a_overflow_flag), 16'h0000);
		no_call(12);
		@(posedge clk);
		timer_a_mode3 <= 1'b0;
	endtask : t_mode3
	// Level trigger: denied request forgotten, flag survives service
	task automatic t_level;
		@(posedge clk);
		ext_b_trigger_type <= 1'b0;
		hold <= 1'b1;
		ev <= 11'h004;
		cyc(10);
		cmp(16'(ext_b_pending), 16'h0001);
		@(posedge clk);
		ev <= '0;
		cyc(10);
		@(posedge clk);
		hold <= 1'b0;
		no_call(16);
		@(posedge clk);
		ev <= 11'h004;
		wait_call(EXP[2]);
		cyc(1);
		cmp(16'(ext_b_pending), 16'h0001);
		@(posedge clk);
		ev <= '0;
		cyc(10);
		ret();
		no_call(16);
	endtask : t_level

	// Reset for 12 cycles, then the scenarios
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		cmp(16'(pend), 16'h0000);
		t_order(1'b0);
		t_order(1'b1);
		t_block();
		t_prio();
		t_mode3();
		t_level();
		test_done();
	end
endmodule : two_level_interrupt_unit_tb
